/* rtl/adsr_regs.sv */
// Status, interrupt mask, flag clear, parameter and version registers
// Summary of operation
// - Ones written to interrupt disable clear matching mask bits
// - Ones written to interrupt enable set matching mask bits
// - Mask bit reads one when its interrupt is enabled
// - Underrun flag in status bit 2 sets on underrun and sticks
// - Underrun flag reads zero after reset or clear until next underrun
// - Transmit ready in status bit 1 reads one when sample can be taken
// - Transmit ready reads zero when no sample can be taken
// - Status bit 0 shows busy during clock domain transfer
// - Ones written to flag clear at 0x24 clear underrun flag or ready interrupt request; ready level stays
// - Zero bits in flag clear leave flags untouched
// - Parameter register at 0x28 is read-only zero
// - Register at 0x2C reports version low twelve bits, variant above
// - Status register at 0x20 is read-only; only its underrun bit resets to zero
// - Registers run on bus clock; conversion side on generic clock
// - Interrupt disable at 0x18, write-only, acts on two bits only
//
// Chosen here: register access over Avalon-MM.
module adsr_regs
  import adsr_pkg::*;
#(
  parameter logic [ADSR_VER_W-1:0] VERSION_NUM = 12'h0a5, // Arbitrary value
  parameter logic [ADSR_VAR_W-1:0] VARIANT_NUM = 4'h0 // Arbitrary value
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [ADSR_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TX_READY_IN,
  input wire logic UNDERRUN_PULSE,
  input wire logic CDC_BUSY,
  output logic IRQ
);
  // Converter side is outside; its indications arrive bus-clock synchronous
  adsr_bus_t state_q;
  logic [1:0] mask_q;
  logic ur_q;
  logic rdy_ev_q;
  logic rdy_prev_q;
  logic [31:0] rdata_q;
  logic acc;
  logic wr_fire;
  logic [31:0] wmask;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign acc = CE && (AVS_READ || AVS_WRITE) && state_q == ADSR_IDLE;
  // Write takes effect when waitrequest drops, the one sampling edge
  assign wr_fire = CE && AVS_WRITE && state_q == ADSR_ANSWER;
  assign AVS_WAITREQUEST = (state_q != ADSR_ANSWER);
  assign AVS_READDATA = rdata_q;
  assign wmask = AVS_WRITEDATA & {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ADSR_IDLE;
    end else if (CE) begin
      case (state_q)
        ADSR_IDLE: begin
          if (acc) begin
            state_q <= ADSR_ANSWER;
          end
        end
        ADSR_ANSWER: state_q <= ADSR_IDLE;
        default: state_q <= ADSR_IDLE;
      endcase
    end
  end

  // Mask; disable wins if both hit in one write, not possible on one bus
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_q <= ADSR_FLAGS_RST;
    end else if (wr_fire && AVS_ADDRESS == ADSR_OFF_IDR) begin
      mask_q <= mask_q & ~wmask[ADSR_BIT_UR:ADSR_BIT_RDY];
    end else if (wr_fire && AVS_ADDRESS == ADSR_OFF_IER) begin
      mask_q <= mask_q | wmask[ADSR_BIT_UR:ADSR_BIT_RDY];
    end
  end

  // Sticky underrun; a new event beats a same-cycle clear
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ur_q <= 1'b0;
    end else if (CE) begin
      if (UNDERRUN_PULSE) begin
        ur_q <= 1'b1;
      end else if (wr_fire && AVS_ADDRESS == ADSR_OFF_SCR && wmask[ADSR_BIT_UR]) begin
        ur_q <= 1'b0;
      end
    end
  end

  // Ready is a live level; its interrupt request is latched on the rise
  // so a clear write can withdraw it while the level stays readable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdy_prev_q <= 1'b0;
      rdy_ev_q <= 1'b0;
    end else if (CE) begin
      rdy_prev_q <= TX_READY_IN;
      if (TX_READY_IN && !rdy_prev_q) begin
        rdy_ev_q <= 1'b1;
      end else if (!TX_READY_IN) begin
        rdy_ev_q <= 1'b0;
      end else if (wr_fire && AVS_ADDRESS == ADSR_OFF_SCR && wmask[ADSR_BIT_RDY]) begin
        rdy_ev_q <= 1'b0;
      end
    end
  end

  always_comb begin
    status_word = ADSR_ZERO;
    status_word[ADSR_BIT_BUSY] = CDC_BUSY;
    status_word[ADSR_BIT_RDY] = TX_READY_IN;
    status_word[ADSR_BIT_UR] = ur_q;
  end

  always_comb begin
    rd_mux = ADSR_ZERO;
    case (AVS_ADDRESS)
      ADSR_OFF_IMR: rd_mux[ADSR_BIT_UR:ADSR_BIT_RDY] = mask_q;
      ADSR_OFF_SR: rd_mux = status_word;
      ADSR_OFF_PARAM: rd_mux = ADSR_ZERO;
      ADSR_OFF_VER: begin
        rd_mux[ADSR_VER_W-1:0] = VERSION_NUM;
        rd_mux[ADSR_VAR_LSB +: ADSR_VAR_W] = VARIANT_NUM;
      end
      default: rd_mux = ADSR_ZERO;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= ADSR_ZERO;
    end else if (CE && acc && AVS_READ) begin
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= (mask_q[1] && ur_q) || (mask_q[0] && rdy_ev_q);
    end
  end

  // Busy guard is the software's job; nothing here blocks it.

  irq_follows_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE
    |=> IRQ == (($past(mask_q[1]) && $past(ur_q)) || ($past(mask_q[0]) && $past(rdy_ev_q))))
    else $error("irq mismatch");

  ur_sticky_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && UNDERRUN_PULSE
    |=> ur_q)
    else $error("underrun not set");

  ur_hold_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    ur_q && !(wr_fire && AVS_ADDRESS == ADSR_OFF_SCR)
    |=> ur_q)
    else $error("underrun lost");

  ur_clear_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    wr_fire && AVS_ADDRESS == ADSR_OFF_SCR && wmask[ADSR_BIT_UR] && !UNDERRUN_PULSE
    |=> !ur_q)
    else $error("clear failed");

  ur_zero_clr_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    ur_q && wr_fire && !wmask[ADSR_BIT_UR]
    |=> ur_q)
    else $error("zero cleared");

  mask_set_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    wr_fire && AVS_ADDRESS == ADSR_OFF_IER && wmask[ADSR_BIT_UR]
    |=> mask_q[1])
    else $error("enable failed");

  mask_clr_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    wr_fire && AVS_ADDRESS == ADSR_OFF_IDR && wmask[ADSR_BIT_RDY]
    |=> !mask_q[0])
    else $error("disable failed");

  rd_status_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_SR
    |=> AVS_READDATA[ADSR_BIT_UR] == $past(ur_q) && !AVS_WAITREQUEST)
    else $error("status read wrong");

  rd_param_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_PARAM
    |=> AVS_READDATA == ADSR_ZERO)
    else $error("param nonzero");

  rd_busy_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_SR
    |=> AVS_READDATA[ADSR_BIT_BUSY] == $past(CDC_BUSY))
    else $error("busy wrong");

  mask_set_rdy_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    wr_fire && AVS_ADDRESS == ADSR_OFF_IER && wmask[ADSR_BIT_RDY]
    |=> mask_q[0])
    else $error("ready enable failed");

  mask_clr_ur_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    wr_fire && AVS_ADDRESS == ADSR_OFF_IDR && wmask[ADSR_BIT_UR]
    |=> !mask_q[1])
    else $error("underrun disable failed");

  mask_keep_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    !(wr_fire && (AVS_ADDRESS == ADSR_OFF_IER || AVS_ADDRESS == ADSR_OFF_IDR))
    |=> $stable(mask_q))
    else $error("mask moved");

  rd_mask_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_IMR
    |=> AVS_READDATA[ADSR_BIT_UR:ADSR_BIT_RDY] == $past(mask_q))
    else $error("mask read wrong");

  rd_rdy_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_SR && TX_READY_IN
    |=> AVS_READDATA[ADSR_BIT_RDY])
    else $error("ready not shown");

  rd_rdy_low_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_SR && !TX_READY_IN
    |=> !AVS_READDATA[ADSR_BIT_RDY])
    else $error("ready shown low side");

  rd_ver_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_VER
    |=> AVS_READDATA[ADSR_VER_W-1:0] == VERSION_NUM)
    else $error("version wrong");

  rd_var_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_VER
    |=> AVS_READDATA[ADSR_VAR_LSB +: ADSR_VAR_W] == VARIANT_NUM)
    else $error("variant wrong");

  rd_sr_upper_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_SR
    |=> (AVS_READDATA >> (ADSR_BIT_UR + 1)) == ADSR_ZERO)
    else $error("status upper bits set");

  ur_rise_only_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    !ur_q && !(CE && UNDERRUN_PULSE)
    |=> !ur_q)
    else $error("underrun set without cause");

  rdy_clear_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    wr_fire && AVS_ADDRESS == ADSR_OFF_SCR && wmask[ADSR_BIT_RDY] && rdy_prev_q
    |=> !rdy_ev_q)
    else $error("ready request not cleared");

  rdy_keep_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && rdy_ev_q && TX_READY_IN && !(wr_fire && AVS_ADDRESS == ADSR_OFF_SCR)
    |=> rdy_ev_q)
    else $error("ready request lost");

  rdy_rise_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && TX_READY_IN && !rdy_prev_q
    |=> rdy_ev_q)
    else $error("ready request missed");

  rdy_fall_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && !TX_READY_IN
    |=> !rdy_ev_q)
    else $error("ready request while not ready");

  irq_low_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && mask_q == ADSR_FLAGS_RST
    |=> !IRQ)
    else $error("irq while masked");

  ur_irq_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && mask_q[1] && ur_q
    |=> IRQ)
    else $error("underrun irq missing");

  rdy_irq_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && mask_q[0] && rdy_ev_q
    |=> IRQ)
    else $error("ready irq missing");

  irq_drop_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && !ur_q && !rdy_ev_q
    |=> !IRQ)
    else $error("irq without flag");

  wait_one_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    acc
    |=> !AVS_WAITREQUEST)
    else $error("no answer after request");

  wait_back_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && !AVS_WAITREQUEST
    |=> AVS_WAITREQUEST)
    else $error("answer held too long");

  ur_ro_wr_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    ur_q && wr_fire && AVS_ADDRESS == ADSR_OFF_SR
    |=> ur_q)
    else $error("status written");

  rdata_hold_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    !(CE && acc && AVS_READ)
    |=> $stable(AVS_READDATA))
    else $error("read data moved");

  rd_unmapped_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && (AVS_ADDRESS > ADSR_OFF_VER || AVS_ADDRESS < ADSR_OFF_IER)
    |=> AVS_READDATA == ADSR_ZERO)
    else $error("unmapped read nonzero");

  rd_wo_zero_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE && acc && AVS_READ && (AVS_ADDRESS == ADSR_OFF_IDR || AVS_ADDRESS == ADSR_OFF_SCR)
    |=> AVS_READDATA == ADSR_ZERO)
    else $error("write-only read nonzero");

  scr_mask_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    wr_fire && AVS_ADDRESS == ADSR_OFF_SCR
    |=> $stable(mask_q))
    else $error("clear touched mask");

  // Main scenarios
  cov_ur_c: cover property (@(posedge CLK) UNDERRUN_PULSE ##1 IRQ);
  cov_clr_c: cover property (@(posedge CLK) wr_fire && AVS_ADDRESS == ADSR_OFF_SCR);
  cov_ver_c: cover property (@(posedge CLK) acc && AVS_READ && AVS_ADDRESS == ADSR_OFF_VER);
  cov_rdy_c: cover property (@(posedge CLK) rdy_ev_q && mask_q[0] ##1 IRQ);
  cov_idr_c: cover property (@(posedge CLK) wr_fire && AVS_ADDRESS == ADSR_OFF_IDR);
endmodule : adsr_regs

/* rtl/adsr_pkg.sv */
// Register map, field layout and constants of the audio converter status block
package adsr_pkg;
  localparam int ADSR_AW = 8;
  localparam logic [7:0] ADSR_OFF_IER = 8'h14;
  localparam logic [7:0] ADSR_OFF_IDR = 8'h18;
  localparam logic [7:0] ADSR_OFF_IMR = 8'h1c;
  localparam logic [7:0] ADSR_OFF_SR = 8'h20;
  localparam logic [7:0] ADSR_OFF_SCR = 8'h24;
  localparam logic [7:0] ADSR_OFF_PARAM = 8'h28;
  localparam logic [7:0] ADSR_OFF_VER = 8'h2c;
  localparam int ADSR_BIT_BUSY = 0;
  localparam int ADSR_BIT_RDY = 1;
  localparam int ADSR_BIT_UR = 2;
  localparam logic [31:0] ADSR_IRQ_BITS = 32'h0000_0006;
  localparam logic [31:0] ADSR_ZERO = 32'h0000_0000;
  localparam logic [1:0] ADSR_FLAGS_RST = 2'h0;
  localparam int ADSR_VER_W = 12;
  localparam int ADSR_VAR_W = 4;
  localparam int ADSR_VAR_LSB = 16;
  typedef enum logic [1:0] {ADSR_IDLE, ADSR_ANSWER} adsr_bus_t;
endpackage : adsr_pkg

/* test/adsr_regs_bench.sv */
// Self-checking bench for the converter status and interrupt registers
module adsr_regs_bench import adsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADSR_AW-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic waitreq;
  logic transmit_ready_flag = 1'b0;
  logic urun = 1'b0;
  logic busy = 1'b0;
  logic irq;
  int n_fail = 0;
  int samples_checked = 0;
  logic ce = 1'b1;
  localparam logic [ADSR_VER_W-1:0] VER_NUM = 12'h3c1; // Arbitrary value
  localparam logic [ADSR_VAR_W-1:0] VAR_NUM = 4'h2; // Arbitrary value
  localparam logic [31:0] VER_WORD = (32'(VAR_NUM) << ADSR_VAR_LSB) | 32'(VER_NUM);
  adsr_regs #(.VERSION_NUM(VER_NUM), .VARIANT_NUM(VAR_NUM)) uut (.CLK(clk), .RSTN(rstn),
    .CE(ce), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .TX_READY_IN(transmit_ready_flag), .UNDERRUN_PULSE(urun),
    .CDC_BUSY(busy), .IRQ(irq));
  always #2.5 clk = ~clk;
  task finish_test;
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : check
  // One access; the request holds until waitrequest is seen low, then a spare edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
    output logic [31:0] q);
    int i;
    addr <= a; wdata <= d; be <= b; rd <= !w; wr <= w;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (waitreq !== 1'b0 && i < 40);
    if (waitreq !== 1'b0) begin
      $display("MISMATCH waitrequest expected 0 seen %b", waitreq);
      n_fail++;
      finish_test();
    end else begin
      q = rdata;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  // Irq is registered: look one edge after the access has settled
  task irq_chk(input string name, input logic exp);
    @(posedge clk);
    check(name, {31'h0, exp}, {31'h0, irq});
  endtask : irq_chk
  task wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wreg
  task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(name, exp, q);
  endtask : rchk
  task t_reset;
    rchk("status", ADSR_OFF_SR, 32'h0);
    rchk("mask", ADSR_OFF_IMR, 32'h0);
    rchk("param", ADSR_OFF_PARAM, 32'h0);
    rchk("version", ADSR_OFF_VER, VER_WORD);
    rchk("unmapped", 8'h40, 32'h0);
  endtask : t_reset
  task t_mask;
    logic [31:0] q;
    bus(1'b1, ADSR_OFF_IER, 32'h6, 4'h0, q);
    rchk("mask", ADSR_OFF_IMR, 32'h0);
    wreg(ADSR_OFF_IER, 32'hffff_ffff);
    rchk("mask", ADSR_OFF_IMR, 32'h6);
    wreg(ADSR_OFF_IDR, 32'h4);
    rchk("mask", ADSR_OFF_IMR, 32'h2);
    wreg(ADSR_OFF_IDR, 32'h0);
    rchk("mask", ADSR_OFF_IMR, 32'h2);
    wreg(ADSR_OFF_IDR, 32'h6);
    rchk("mask", ADSR_OFF_IMR, 32'h0);
  endtask : t_mask
  task t_underrun;
    urun <= 1'b1;
    @(posedge clk);
    urun <= 1'b0;
    @(posedge clk);
    rchk("status", ADSR_OFF_SR, 32'h4);
    wreg(ADSR_OFF_SR, 32'hffff_ffff);
    wreg(ADSR_OFF_SCR, 32'h2);
    rchk("status", ADSR_OFF_SR, 32'h4);
    irq_chk("irq", 1'b0);
    wreg(ADSR_OFF_IER, 32'h4);
    irq_chk("irq", 1'b1);
    wreg(ADSR_OFF_SCR, 32'h4);
    irq_chk("irq", 1'b0);
    rchk("status", ADSR_OFF_SR, 32'h0);
    wreg(ADSR_OFF_IDR, 32'h4);
  endtask : t_underrun
  task t_ready;
    // Control writes to IER and SCR are issued while busy is high.
    transmit_ready_flag <= 1'b1; busy <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    rchk("status", ADSR_OFF_SR, 32'h3);
    wreg(ADSR_OFF_IER, 32'h2);
    irq_chk("irq", 1'b1);
    wreg(ADSR_OFF_SCR, 32'h2);
    irq_chk("irq", 1'b0);
    busy <= 1'b0; transmit_ready_flag <= 1'b0;
    @(posedge clk);
    rchk("status", ADSR_OFF_SR, 32'h0);
  endtask : t_ready
  // Enable low must freeze the sticky flag against a pulse
  task t_ce;
    ce <= 1'b0;
    urun <= 1'b1;
    @(posedge clk);
    urun <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    rchk("status", ADSR_OFF_SR, 32'h0);
  endtask : t_ce
  // Reset in mid-run clears flag, mask and irq
  task t_rst2;
    urun <= 1'b1;
    @(posedge clk);
    urun <= 1'b0;
    wreg(ADSR_OFF_IER, 32'h6);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk("status", ADSR_OFF_SR, 32'h0);
    rchk("mask", ADSR_OFF_IMR, 32'h0);
    irq_chk("irq", 1'b0);
  endtask : t_rst2
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_mask();
    t_underrun();
    t_ready();
    t_ce();
    t_rst2();
    finish_test();
  end
endmodule : adsr_regs_bench
